/* File: logic/sst_pkg.sv */
// shared constants, pin bundles and state types of the spi shift core
`default_nettype none

package sst_pkg;

	// widths and frame lengths
	localparam int DATA_W    = 16;
	localparam int EDGE_W    = 6;
	localparam int BYTE_BITS = 8;
	localparam int WORD_BITS = 16;

	// master serial clock timing: half period in ns and in system cycles
	localparam int CLK_NS       = 25;
	localparam int SCK_HALF_NS  = 100;
	localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int DIV_W        = 4;

	// reset values
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam logic [3:0]        PIN_RST  = 4'hF;

	// pins sampled from the link
	typedef struct packed {
		logic sck;
		logic mosi;
		logic miso;
		logic ss_n;
	} sst_pin_in_t;

	// pins driven onto the link, each with its output enable
	typedef struct packed {
		logic sck;
		logic sck_oe;
		logic mosi;
		logic mosi_oe;
		logic miso;
		logic miso_oe;
	} sst_pin_out_t;

	localparam sst_pin_out_t PIN_OUT_RST = 6'h00;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_XFER,
		ST_TRAIL
	} sst_state_t;

endpackage : sst_pkg

`default_nettype wire

/* File: logic/sst_core.sv */
// spi shift and transfer core: master or slave, cpha=1 format
// Function
// - on odd edges from the third, shift the latched bit in per bit order
// - sample on even edges, shift on odd edges from the third; the last even edge samples and shifts the final bit
// - after each shift edge the master drives its next bit on mosi
// - receive into shift register, copy to data register after last bit
// - after 2n edges master and slave data registers are exchanged
// - done flag set on copy, held until status read then data read
// - tx empty flag set when data register free, held until serviced
// - as master, own select must stay high or be ignored
// - miso driven only by slave, mosi only by master, sck only by master
// - width select clear gives eight-bit frames for either clock polarity
`default_nettype none

module sst_core
	import sst_pkg::*;
(
	input  wire logic                 clk_sys_i,
	input  wire logic                 reset_i,
	input  wire logic                 master_mode_i,
	input  wire logic                 clock_polarity_i,
	input  wire logic                 bit_order_select_i,
	input  wire logic                 transfer_width_select_i,
	input  wire logic [sst_pkg::DATA_W-1:0] tx_data_i,
	input  wire logic                 data_write_i,
	input  wire logic                 data_read_i,
	input  wire logic                 status_read_i,
	input  wire sst_pkg::sst_pin_in_t pin_i,
	output var  sst_pkg::sst_pin_out_t pin_o,
	output var  logic [sst_pkg::DATA_W-1:0] rx_data_o,
	output var  logic                 transfer_done_flag_o,
	output var  logic                 tx_empty_flag_o,
	output var  logic                 busy_o
);
	import sst_pkg::*;

	// frame length in bits from the width select
	function automatic logic [EDGE_W-1:0] frame_bits(input logic wide);
		frame_bits = wide ? EDGE_W'(WORD_BITS) : EDGE_W'(BYTE_BITS);
	endfunction

	// index of the top bit of the active frame
	function automatic logic [3:0] top_bit(input logic wide);
		top_bit = wide ? 4'(WORD_BITS - 1) : 4'(BYTE_BITS - 1);
	endfunction

	// shift one bit in at the end chosen by the bit order
	function automatic logic [DATA_W-1:0] shift_in(
		input logic [DATA_W-1:0] d,
		input logic              b,
		input logic              lsb_first,
		input logic              wide
	);
		logic [DATA_W-1:0] r;
		r = DATA_RST;
		if (lsb_first) begin
			r = d >> 1;
			if (!wide)
				r[DATA_W-1:BYTE_BITS] = 8'h00;
			r[top_bit(wide)] = b;
		end else begin
			r = {d[DATA_W-2:0], b};
			if (!wide)
				r[DATA_W-1:BYTE_BITS] = 8'h00;
		end
		shift_in = r;
	endfunction

	// bit leaving the shift register next
	function automatic logic out_bit(
		input logic [DATA_W-1:0] d,
		input logic              lsb_first,
		input logic              wide
	);
		out_bit = lsb_first ? d[0] : d[top_bit(wide)];
	endfunction

	logic [3:0]        sync1;
	logic [3:0]        sync2;
	logic [3:0]        sync3;
	sst_pin_in_t       pin_f;
	sst_pin_in_t       pin_h;
	logic              sck_prev;
	logic              ss_prev;
	sst_state_t        state;
	logic [DIV_W-1:0]  div_cnt;
	logic              tick;
	logic [EDGE_W-1:0] edge_cnt;
	logic [EDGE_W-1:0] next_edge;
	logic              edge_evt;
	logic              last_edge;
	logic [DATA_W-1:0] shreg;
	logic [DATA_W-1:0] tx_reg;
	logic              latched;
	logic              done_armed;
	logic              empty_armed;
	logic              start_m;
	logic              start_s;
	logic              abort_s;
	logic              frame_end;
	logic              din;

	// three-stage pin synchroniser; pin_h keeps the last agreed level
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			sync1 <= PIN_RST;
			sync2 <= PIN_RST;
			sync3 <= PIN_RST;
			pin_h <= PIN_RST;
		end else begin
			sync1 <= pin_i;
			sync2 <= sync1;
			sync3 <= sync2;
			pin_h <= pin_f;
		end
	end

	// a change counts once stages 2 and 3 agree; no extra register here,
	// or the far side's bit would reach the master half a period late
	assign pin_f = (sync2 & sync3) | (pin_h & (sync2 ^ sync3));

	// previous filtered levels for edge detection
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			sck_prev <= 1'b1; // matches the filtered reset level
			ss_prev  <= 1'b1;
		end else begin
			sck_prev <= pin_f.sck;
			ss_prev  <= pin_f.ss_n;
		end
	end

	// master half-period divider, restarted at every frame start
	always_ff @(posedge clk_sys_i) begin
		if (reset_i || state == ST_IDLE) begin
			div_cnt <= '0;
			tick    <= 1'b0;
		end else if (div_cnt == DIV_W'(SCK_HALF_CYC - 1)) begin
			div_cnt <= '0;
			tick    <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 1'b1;
			tick    <= 1'b0;
		end
	end

	// master starts only with data queued and its own select high
	assign start_m = (state == ST_IDLE) && master_mode_i &&
		!tx_empty_flag_o && pin_f.ss_n;
	assign start_s = (state == ST_IDLE) && !master_mode_i &&
		!pin_f.ss_n && ss_prev;
	assign abort_s = !master_mode_i && pin_f.ss_n && (state != ST_IDLE);

	// edge events: own divider as master, sampled sck changes as slave
	assign edge_evt = (state == ST_XFER) && (master_mode_i ? tick :
		(pin_f.sck != sck_prev) && !pin_f.ss_n);
	assign next_edge = edge_cnt + 1'b1;
	assign last_edge = next_edge ==
		EDGE_W'({frame_bits(transfer_width_select_i), 1'b0});
	assign frame_end = edge_evt && last_edge;
	assign din = master_mode_i ? pin_f.miso : pin_f.mosi;

	// frame sequencer; one trailing half period after the last master edge
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_m || start_s)
						state <= ST_XFER;
				end
				ST_XFER: begin
					if (abort_s)
						state <= ST_IDLE;
					else if (frame_end)
						state <= master_mode_i ? ST_TRAIL : ST_IDLE;
				end
				ST_TRAIL: begin
					if (tick || !master_mode_i)
						state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// edge counter and shift datapath
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			edge_cnt <= '0;
			shreg    <= DATA_RST;
			latched  <= 1'b0;
		end else if (start_m || start_s) begin
			edge_cnt <= '0;
			shreg    <= tx_reg;
		end else if (edge_evt) begin
			edge_cnt <= next_edge;
			if (!next_edge[0])
				latched <= din; // sample on even edges
			if (last_edge)
				shreg <= shift_in(shreg, din, bit_order_select_i,
					transfer_width_select_i); // final bit
			else if (next_edge[0] && next_edge != EDGE_W'(1))
				shreg <= shift_in(shreg, latched, bit_order_select_i,
					transfer_width_select_i);
		end
	end

	// received word moves to the data register only at frame end
	always_ff @(posedge clk_sys_i) begin
		if (reset_i)
			rx_data_o <= DATA_RST;
		else if (frame_end)
			rx_data_o <= shift_in(shreg, din, bit_order_select_i,
				transfer_width_select_i);
	end

	// transmit data register written by software
	always_ff @(posedge clk_sys_i) begin
		if (reset_i)
			tx_reg <= DATA_RST;
		else if (data_write_i)
			tx_reg <= tx_data_i;
	end

	// done flag: status read arms, data read clears; a new set wins
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			transfer_done_flag_o <= 1'b0;
			done_armed           <= 1'b0;
		end else if (frame_end) begin
			transfer_done_flag_o <= 1'b1;
			done_armed           <= 1'b0;
		end else if (status_read_i && transfer_done_flag_o) begin
			done_armed <= 1'b1;
		end else if (data_read_i && done_armed) begin
			transfer_done_flag_o <= 1'b0;
			done_armed           <= 1'b0;
		end
	end

	// empty flag: set when the word moves to the shift register
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			tx_empty_flag_o <= 1'b1;
			empty_armed     <= 1'b0;
		end else if (start_m || start_s) begin
			tx_empty_flag_o <= 1'b1;
			empty_armed     <= 1'b0;
		end else if (status_read_i && tx_empty_flag_o) begin
			empty_armed <= 1'b1;
		end else if (data_write_i && empty_armed) begin
			tx_empty_flag_o <= 1'b0;
			empty_armed     <= 1'b0;
		end
	end

	// sck: master drives, idle at the selected polarity
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			pin_o.sck    <= 1'b0;
			pin_o.sck_oe <= 1'b0;
		end else begin
			pin_o.sck_oe <= master_mode_i;
			if (state == ST_XFER && master_mode_i && tick)
				pin_o.sck <= !pin_o.sck;
			else if (state == ST_IDLE)
				pin_o.sck <= clock_polarity_i;
		end
	end

	// serial output: first bit at edge one, next bit after each shift
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			pin_o.mosi    <= 1'b0;
			pin_o.mosi_oe <= 1'b0;
			pin_o.miso    <= 1'b0;
			pin_o.miso_oe <= 1'b0;
		end else begin
			pin_o.mosi_oe <= master_mode_i;
			pin_o.miso_oe <= !master_mode_i && !pin_f.ss_n;
			if (edge_evt && next_edge[0] && !last_edge) begin
				if (next_edge == EDGE_W'(1)) begin
					pin_o.mosi <= out_bit(shreg, bit_order_select_i,
						transfer_width_select_i);
					pin_o.miso <= out_bit(shreg, bit_order_select_i,
						transfer_width_select_i);
				end else begin
					// after shifting, the next outgoing bit is at the exit
					pin_o.mosi <= out_bit(shift_in(shreg, latched,
						bit_order_select_i, transfer_width_select_i),
						bit_order_select_i, transfer_width_select_i);
					pin_o.miso <= out_bit(shift_in(shreg, latched,
						bit_order_select_i, transfer_width_select_i),
						bit_order_select_i, transfer_width_select_i);
				end
			end
		end
	end

	// busy while a frame or its trailing time runs
	always_ff @(posedge clk_sys_i) begin
		if (reset_i)
			busy_o <= 1'b0;
		else
			busy_o <= (state != ST_IDLE) || start_m || start_s;
	end

endmodule // sst_core

`default_nettype wire

/* File: verification/sst_core_monitor.sv */
// assertion checker bound to the spi shift core ports
`default_nettype none

module sst_core_monitor
	import sst_pkg::*;
(
	input wire logic                        clk_sys_i,
	input wire logic                        reset_i,
	input wire logic                        master_mode_i,
	input wire logic                        transfer_width_select_i,
	input wire logic                        data_write_i,
	input wire logic                        data_read_i,
	input wire sst_pkg::sst_pin_out_t       pin_o,
	input wire logic [sst_pkg::DATA_W-1:0] rx_data_o,
	input wire logic                        transfer_done_flag_o,
	input wire logic                        tx_empty_flag_o,
	input wire logic                        busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       sck_q;
	logic [5:0] n_edge;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	// count sck toggles in a frame; a slipped divider gives a short count
	always_ff @(posedge clk_sys_i) begin
		sck_q <= pin_o.sck;
		if (reset_i || !busy_o) begin
			n_edge <= 6'h00;
		end else if (sck_q != pin_o.sck) begin
			n_edge <= n_edge + 6'h01;
		end
	end
	a_rx_on_done:
	assert property ($changed(rx_data_o) |-> transfer_done_flag_o)
		else $error("rx word moved without done flag");
	a_done_hold:
	assert property (transfer_done_flag_o && !data_read_i |=>
		transfer_done_flag_o) else $error("done flag dropped unserviced");
	a_done_end:
	assert property ($rose(transfer_done_flag_o) && master_mode_i |->
		busy_o ##[1:8] !busy_o) else $error("done not at frame end");
	a_empty_hold:
	assert property ($fell(tx_empty_flag_o) |-> $past(data_write_i))
		else $error("tx empty dropped without write");
	a_empty_start:
	assert property ($rose(busy_o) |-> $rose(tx_empty_flag_o))
		else $error("frame start did not set tx empty");
	a_pin_roles:
	assert property (master_mode_i && $past(master_mode_i) &&
		!$past(reset_i) |-> pin_o.mosi_oe && pin_o.sck_oe &&
		!pin_o.miso_oe) else $error("master drives wrong lines");
	a_frame_edges:
	assert property ($fell(busy_o) && master_mode_i |-> n_edge ==
		(transfer_width_select_i ? 6'h20 : 6'h10))
		else $error("wrong sck edge count in frame");
	a_busy_len:
	assert property ($rose(busy_o) |-> busy_o[*8])
		else $error("frame ended too early");
	c_wide: cover property ($fell(busy_o) && transfer_width_select_i);
	c_done_clr: cover property ($fell(transfer_done_flag_o));
	c_empty_clr: cover property ($fell(tx_empty_flag_o));
endmodule // sst_core_monitor

`default_nettype wire

/* File: verification/sst_slave_model.sv */
// behavioural slave: cpha=1 shifting against the core's sck and mosi
`default_nettype none

module sst_slave_model
	import sst_pkg::*;
(
	input  wire logic              sck_i,
	input  wire logic              mosi_i,
	input  wire logic              sel_n_i,
	input  wire logic              lsb_first_i,
	input  wire logic              wide_i,
	input  wire logic [DATA_W-1:0] word_i,
	output var  logic              miso_o,
	output var  logic [DATA_W-1:0] got_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int e = 0;
	int n;
	int k;
	initial miso_o = 1'h0;
	// a new select restarts the edge count and clears the capture
	always @(negedge sel_n_i) begin
		e = 0;
		got_o = '0;
	end
	// released line shows the inverse of its last bit, never a held value
	always @(posedge sel_n_i) miso_o = ~miso_o;
	// odd edges drive the next bit, even edges sample mosi
	always @(sck_i) begin
		n = wide_i ? WORD_BITS : BYTE_BITS;
		if (!sel_n_i && e < 2 * n) begin
			e++;
			k = (e - 1) / 2;
			if (e % 2) begin
				miso_o = word_i[lsb_first_i ? k : n - 1 - k];
			end else begin
				got_o[lsb_first_i ? k : n - 1 - k] = mosi_i;
			end
		end
	end
endmodule // sst_slave_model

`default_nettype wire

/* File: verification/testbench.sv */
// top bench: core as master against the behavioural slave
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import sst_pkg::*;
	logic              clk;
	logic              rst = 1'h1;
	logic              pol = 1'h0;
	logic              lsb = 1'h0;
	logic              wide = 1'h0;
	logic              sel_n = 1'h1;
	logic [2:0]        stb = 3'h0;
	logic [DATA_W-1:0] tx = 16'h0000;
	logic [DATA_W-1:0] sw_word = 16'h0000;
	logic [DATA_W-1:0] rx;
	logic [DATA_W-1:0] got;
	logic              done;
	logic              empty;
	logic              busy;
	logic              sl_miso;
	sst_pin_in_t       pin_i;
	sst_pin_out_t      pin_o;
	int                mismatches = 0;
	int                checked = 0;
	// resolve wires from each enable; own select held high as master
	assign pin_i = {pin_o.sck_oe ? pin_o.sck : 1'h1,
		pin_o.mosi_oe ? pin_o.mosi : 1'h1,
		pin_o.miso_oe ? pin_o.miso : sl_miso, 1'h1};
	sst_core i_sst_core (
		.clk_sys_i(clk), .reset_i(rst), .master_mode_i(1'h1),
		.clock_polarity_i(pol), .bit_order_select_i(lsb),
		.transfer_width_select_i(wide), .tx_data_i(tx),
		.data_write_i(stb[1]), .data_read_i(stb[0]),
		.status_read_i(stb[2]), .pin_i(pin_i), .pin_o(pin_o),
		.rx_data_o(rx), .transfer_done_flag_o(done),
		.tx_empty_flag_o(empty), .busy_o(busy));
	sst_slave_model i_sst_slave_model (
		.sck_i(pin_i.sck), .mosi_i(pin_i.mosi), .sel_n_i(sel_n),
		.lsb_first_i(lsb), .wide_i(wide), .word_i(sw_word),
		.miso_o(sl_miso), .got_o(got));
	// 40 MHz system clock
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk_w(input string nm, input logic [DATA_W-1:0] e,
		input logic [DATA_W-1:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chk_b(input string nm, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s exp %b got %b", nm, e, g);
		end
	endtask
	// one-cycle strobe {status read, data write, data read}
	task automatic pulse(input logic [2:0] v);
		stb = v;
		@(posedge clk) #2 stb = 3'h0;
		@(posedge clk) #2;
	endtask
	// one full exchange, then the flag servicing order
	task automatic frame(input logic [DATA_W-1:0] m,
		input logic [DATA_W-1:0] s);
		int k;
		logic [DATA_W-1:0] msk;
		msk = wide ? 16'hFFFF : 16'h00FF;
		tx = m;
		sw_word = s;
		pulse(3'h4);
		// select only once sck has settled at the new idle level
		sel_n = 1'h0;
		pulse(3'h2);
		for (k = 0; k < 400 && done !== 1'h1; k++) @(posedge clk) #2;
		chk_b("done", 1'h1, done);
		chk_w("rx", s & msk, rx);
		chk_w("slave rx", m & msk, got);
		chk_b("empty", 1'h1, empty);
		sel_n = 1'h1;
		pulse(3'h1);
		chk_b("done unarmed", 1'h1, done);
		pulse(3'h4);
		pulse(3'h1);
		chk_b("done cleared", 1'h0, done);
	endtask
	task automatic wrap_up();
		if (mismatches == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// main sequence: unarmed write, then every polarity, order and width
	initial begin
		int i;
		repeat (6) @(posedge clk);
		#2 rst = 1'h0;
		repeat (4) @(posedge clk);
		#2 pulse(3'h2);
		chk_b("empty unarmed", 1'h1, empty);
		chk_b("busy unarmed", 1'h0, busy);
		for (i = 0; i < 8; i++) begin
			{pol, lsb, wide} = i[2:0];
			frame(16'hC35A ^ 16'(i * 4369), 16'h96E1 + 16'(i));
		end
		wrap_up();
	end
	// watchdog: eight frames need well under this span
	initial begin
		#200us;
		mismatches++;
		wrap_up();
	end
endmodule // testbench

bind sst_core sst_core_monitor i_sst_core_monitor (
	.clk_sys_i(clk_sys_i), .reset_i(reset_i), .master_mode_i(master_mode_i),
	.transfer_width_select_i(transfer_width_select_i),
	.data_write_i(data_write_i), .data_read_i(data_read_i), .pin_o(pin_o),
	.rx_data_o(rx_data_o), .transfer_done_flag_o(transfer_done_flag_o),
	.tx_empty_flag_o(tx_empty_flag_o), .busy_o(busy_o));

`default_nettype wire
